// ### rtl/diskette_regs_pkg.sv
// constants, carrier structs and state encodings for the diskette register
// bank; assumes a 100 MHz core clock and an 8-bit host I/O bus
package diskette_regs_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 10;

	// host I/O addresses, primary and secondary groups
	localparam logic [9:0] ADDR_DTYPE_PRI = 10'h3F1;
	localparam logic [9:0] ADDR_OUTCTL_PRI = 10'h3F2;
	localparam logic [9:0] ADDR_STATUS_PRI = 10'h3F4;
	localparam logic [9:0] ADDR_DATA_PRI = 10'h3F5;
	localparam logic [9:0] ADDR_DIAG_PRI = 10'h3F7;
	localparam logic [9:0] ADDR_FIXED_PRI = 10'h1F7;
	localparam logic [9:0] ADDR_DTYPE_SEC = 10'h371;
	localparam logic [9:0] ADDR_OUTCTL_SEC = 10'h372;
	localparam logic [9:0] ADDR_STATUS_SEC = 10'h374;
	localparam logic [9:0] ADDR_DATA_SEC = 10'h375;
	localparam logic [9:0] ADDR_DIAG_SEC = 10'h377;
	localparam logic [9:0] ADDR_FIXED_SEC = 10'h177;

	// decoded register selector
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_DTYPE = 3'h1;
	localparam logic [2:0] SEL_OUTCTL = 3'h2;
	localparam logic [2:0] SEL_STATUS = 3'h3;
	localparam logic [2:0] SEL_DATA = 3'h4;
	localparam logic [2:0] SEL_DIAG = 3'h5;
	localparam logic [2:0] SEL_FIXED = 3'h6;

	// output control register fields and reset value
	localparam int OC_MOTOR_B = 5;
	localparam int OC_MOTOR_A = 4;
	localparam int OC_INT_DMA = 3;
	localparam int OC_FUNC_RUN = 2;
	localparam int OC_DRIVE_SEL = 0;
	localparam logic [7:0] OUTCTL_RESET = 8'h00;

	// transfer rate codes and reset value
	localparam logic [1:0] RATE_500K = 2'h0;
	localparam logic [1:0] RATE_300K = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	localparam logic [1:0] RATE_RSVD = 2'h3;
	localparam logic [1:0] RATE_RESET = RATE_500K;

	// fixed disk status value, bit 7 forced high
	localparam logic [7:0] FIXED_STATUS = 8'h80;

	// write pulse widths (longest time, rounded down)
	localparam int WR_PULSE_8M_NS = 150;
	localparam int WR_PULSE_4M8_NS = 208;
	localparam int WR_PULSE_4M_NS = 250;
	localparam logic [4:0] WR_CYC_8M = 5'(WR_PULSE_8M_NS / CLK_PERIOD_NS);
	localparam logic [4:0] WR_CYC_4M8 = 5'(WR_PULSE_4M8_NS / CLK_PERIOD_NS);
	localparam logic [4:0] WR_CYC_4M = 5'(WR_PULSE_4M_NS / CLK_PERIOD_NS);

	// bit cell periods per rate
	localparam int CELL_500K_NS = 2000;
	localparam int CELL_300K_NS = 3333;
	localparam int CELL_250K_NS = 4000;
	localparam logic [8:0] CELL_CYC_500K = 9'(CELL_500K_NS / CLK_PERIOD_NS);
	localparam logic [8:0] CELL_CYC_300K = 9'(CELL_300K_NS / CLK_PERIOD_NS);
	localparam logic [8:0] CELL_CYC_250K = 9'(CELL_250K_NS / CLK_PERIOD_NS);

	// step timing (least times, rounded up)
	localparam int DIR_SETUP_NS = 1000;
	localparam int STEP_ACTIVE_NS = 5000;
	localparam int DIR_HOLD_NS = 24000;
	localparam logic [11:0] DIR_SETUP_CYC =
		12'((DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] STEP_ACTIVE_CYC =
		12'((STEP_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] DIR_HOLD_CYC =
		12'((DIR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// step sequencer states
	typedef enum logic [3:0] {
		STEP_IDLE   = 4'b0001,
		STEP_SETUP  = 4'b0010,
		STEP_ACTIVE = 4'b0100,
		STEP_HOLD   = 4'b1000
	} step_state_t;

	// status handed up by the command engine
	typedef struct packed {
		logic nonDma;
		logic busy;
		logic seekB;
		logic seekA;
	} core_status_t;

	// drive-side inputs
	typedef struct packed {
		logic trackZero_n;
		logic writeProtect_n;
		logic index_n;
		logic diskChange;
	} drive_in_t;

	// drive-side outputs, all active high
	typedef struct packed {
		logic headSelect;
		logic step;
		logic direction;
		logic motorA;
		logic motorB;
		logic selectA;
		logic selectB;
		logic writeGate;
		logic writeData;
		logic reducedWrite;
	} drive_out_t;

endpackage

// ### rtl/diskette_host_regs.sv
// host register bank and drive port of a two-drive diskette controller
// assumes host pins and drive pins are asynchronous to clk; the command
// engine sits beside it on clk and talks through the core-side ports
`timescale 1ns/100ps

module diskette_host_regs
	import diskette_regs_pkg::*;
#(
	parameter int STACK_DEPTH = 16
) (
	input  wire logic                            clk,
	input  wire logic                            reset_n,
	input  wire logic [9:0]                      hostAddr,
	input  wire logic [7:0]                      hostDataIn,
	output logic [7:0]                           hostDataOut,
	output logic                                 hostDataOe_n,
	input  wire logic                            ioRead_n,
	input  wire logic                            ioWrite_n,
	input  wire logic                            addrEnable,
	input  wire logic                            driveGroupSelect,
	input  wire logic                            densityHighA,
	input  wire logic                            densityHighB,
	input  wire logic                            hard_disk_present_n,
	input  wire logic [6:0]                      fixedDiskBits,
	input  wire diskette_regs_pkg::drive_in_t    driveIn,
	output diskette_regs_pkg::drive_out_t        driveOut,
	input  wire diskette_regs_pkg::core_status_t coreStatus,
	input  wire logic                            cmdPop,
	output logic [7:0]                           cmdByte,
	output logic                                 cmdAvail,
	input  wire logic                            resultPush,
	input  wire logic [7:0]                      resultByte,
	input  wire logic                            stepReq,
	input  wire logic                            stepOutward,
	input  wire logic                            headUpper,
	input  wire logic                            writeGateReq,
	input  wire logic                            writeBitReq,
	output logic                                 stepDone,
	output logic                                 bitCellTick,
	output logic                                 coreRun,
	output logic                                 intDmaEnable,
	output diskette_regs_pkg::drive_in_t         driveInSync
);
	import diskette_regs_pkg::*;

	localparam int PIN_W = 36;
	localparam int PW = $clog2(STACK_DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(STACK_DEPTH);

	// address decode, shared by read and write paths
	function automatic logic [2:0] decode(input logic [9:0] a,
		input logic primary, input logic noHardCard);
		logic [2:0] s;
		s = SEL_NONE;
		if (primary) begin
			if (a == ADDR_DTYPE_PRI) s = SEL_DTYPE;
			if (a == ADDR_OUTCTL_PRI) s = SEL_OUTCTL;
			if (a == ADDR_STATUS_PRI) s = SEL_STATUS;
			if (a == ADDR_DATA_PRI) s = SEL_DATA;
			if (a == ADDR_DIAG_PRI) s = SEL_DIAG;
			if (a == ADDR_FIXED_PRI && noHardCard) s = SEL_FIXED;
		end else begin
			if (a == ADDR_DTYPE_SEC) s = SEL_DTYPE;
			if (a == ADDR_OUTCTL_SEC) s = SEL_OUTCTL;
			if (a == ADDR_STATUS_SEC) s = SEL_STATUS;
			if (a == ADDR_DATA_SEC) s = SEL_DATA;
			if (a == ADDR_DIAG_SEC) s = SEL_DIAG;
			if (a == ADDR_FIXED_SEC && noHardCard) s = SEL_FIXED;
		end
		return s;
	endfunction

	logic [1:0]       rstPipe;
	logic             rstN;
	logic [PIN_W-1:0] pinMeta, pinSync;
	logic             iorS, iowS, aenS, groupS, densAS, densBS, hdcS;
	logic [9:0]       addrS;
	logic [7:0]       dataS;
	logic [6:0]       fixedS;
	drive_in_t        drvS;
	logic             iorPrev, iowPrev, rdRise, wrRise;
	logic [2:0]       rdSel, wrSel_reg, rdSel_reg;
	logic [7:0]       wrData_reg;
	logic [7:0]       output_control_reg;
	logic [1:0]       rate_reg;
	logic             funcRun;
	logic [7:0]       cmdMem [STACK_DEPTH];
	logic [7:0]       resMem [STACK_DEPTH];
	logic [PW-1:0]    cmdWr, cmdRd, resWr, resRd;
	logic [PW:0]      cmdCount, resCount;
	logic             cmdPush, resPop, doCmdPop, doResPush;
	logic [7:0]       statusByte, readMux;
	logic [8:0]       cellCnt, cellLen;
	logic [4:0]       wrCnt, wrLen;
	logic             wrPulse;
	step_state_t      stepState_reg;
	logic [11:0]      stepCnt;
	logic             stepDir_reg;

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) rstPipe <= 2'h0;
		else rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstN = rstPipe[1];

	// two-flop synchroniser for every pin input; idle strobes read high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta <= '1;
			pinSync <= '1;
		end else begin
			pinMeta <= {ioRead_n, ioWrite_n, addrEnable, hostAddr, hostDataIn,
				driveGroupSelect, densityHighA, densityHighB,
				hard_disk_present_n, fixedDiskBits, driveIn};
			pinSync <= pinMeta;
		end
	end
	assign {iorS, iowS, aenS, addrS, dataS, groupS, densAS, densBS, hdcS,
		fixedS, drvS} = pinSync;

	// strobe edges; a write commits on the trailing edge of its strobe
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			iorPrev <= 1'b1;
			iowPrev <= 1'b1;
		end else begin
			iorPrev <= iorS;
			iowPrev <= iowS;
		end
	end
	assign rdRise = iorS & ~iorPrev;
	assign wrRise = iowS & ~iowPrev;
	assign rdSel = decode(addrS, groupS, hdcS);

	// capture address and data while a strobe is low; cycles while the
	// DMA owns the bus are dropped, so no register sees them
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrSel_reg <= SEL_NONE;
			rdSel_reg <= SEL_NONE;
			wrData_reg <= 8'h00;
		end else begin
			if (!iowS) begin
				wrSel_reg <= aenS ? SEL_NONE : rdSel;
				wrData_reg <= dataS;
			end else if (wrRise) begin
				wrSel_reg <= SEL_NONE;
			end
			if (!iorS) rdSel_reg <= aenS ? SEL_NONE : rdSel;
			else if (rdRise) rdSel_reg <= SEL_NONE;
		end
	end

	// output control register, write-only, cleared by host reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) output_control_reg <= OUTCTL_RESET;
		else if (wrRise && wrSel_reg == SEL_OUTCTL)
			output_control_reg <= wrData_reg;
	end
	assign funcRun = output_control_reg[OC_FUNC_RUN];

	// rate register shares the diagnostic address; reserved code ignored
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) rate_reg <= RATE_RESET;
		else if (wrRise && wrSel_reg == SEL_DIAG &&
			wrData_reg[1:0] != RATE_RSVD)
			rate_reg <= wrData_reg[1:0];
	end

	// command bytes written by the host, drained by the engine
	assign cmdPush = wrRise && wrSel_reg == SEL_DATA && cmdCount != FULL;
	assign doCmdPop = cmdPop && cmdCount != '0;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cmdWr <= '0;
			cmdRd <= '0;
			cmdCount <= '0;
		end else if (!funcRun) begin
			cmdWr <= '0;
			cmdRd <= '0;
			cmdCount <= '0;
		end else begin
			if (cmdPush) cmdWr <= cmdWr + 1'b1;
			if (doCmdPop) cmdRd <= cmdRd + 1'b1;
			cmdCount <= cmdCount + (PW+1)'(cmdPush) - (PW+1)'(doCmdPop);
		end
	end
	always_ff @(posedge clk) begin
		if (cmdPush) cmdMem[cmdWr] <= wrData_reg;
	end

	// result bytes pushed by the engine, read by the host one at a time
	assign resPop = rdRise && rdSel_reg == SEL_DATA && resCount != '0;
	assign doResPush = resultPush && resCount != FULL;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			resWr <= '0;
			resRd <= '0;
			resCount <= '0;
		end else if (!funcRun) begin
			resWr <= '0;
			resRd <= '0;
			resCount <= '0;
		end else begin
			if (doResPush) resWr <= resWr + 1'b1;
			if (resPop) resRd <= resRd + 1'b1;
			resCount <= resCount + (PW+1)'(doResPush) - (PW+1)'(resPop);
		end
	end
	always_ff @(posedge clk) begin
		if (doResPush) resMem[resWr] <= resultByte;
	end

	// main status: ready follows whichever stack the direction points at
	always_comb begin
		statusByte = 8'h00;
		statusByte[6] = resCount != '0;
		statusByte[7] = funcRun &&
			(statusByte[6] || cmdCount != FULL);
		statusByte[5] = coreStatus.nonDma;
		statusByte[4] = coreStatus.busy;
		statusByte[1] = coreStatus.seekB;
		statusByte[0] = coreStatus.seekA;
	end

	// read multiplexer; write-only addresses do not answer
	always_comb begin
		case (rdSel_reg)
			SEL_DTYPE: readMux = {6'h00, densBS, densAS};
			SEL_STATUS: readMux = statusByte;
			SEL_DATA: readMux = resMem[resRd];
			SEL_DIAG: readMux = {drvS.diskChange, fixedS};
			SEL_FIXED: readMux = FIXED_STATUS;
			default: readMux = 8'h00;
		endcase
	end

	// data bus drive, enable low while a readable register answers
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			hostDataOut <= 8'h00;
			hostDataOe_n <= 1'b1;
		end else begin
			hostDataOut <= readMux;
			hostDataOe_n <= iorS || rdSel_reg == SEL_NONE ||
				rdSel_reg == SEL_OUTCTL;
		end
	end

	// bit cell divider; one-cycle enable at the selected transfer rate
	always_comb begin
		case (rate_reg)
			RATE_300K: cellLen = CELL_CYC_300K;
			RATE_250K: cellLen = CELL_CYC_250K;
			default: cellLen = CELL_CYC_500K;
		endcase
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cellCnt <= 9'h000;
			bitCellTick <= 1'b0;
		end else begin
			bitCellTick <= funcRun && cellCnt == 9'h000;
			if (!funcRun || cellCnt == 9'h000) cellCnt <= cellLen - 9'h001;
			else cellCnt <= cellCnt - 9'h001;
		end
	end

	// write pulse width tracks the rate; no pulse without the write gate
	always_comb begin
		case (rate_reg)
			RATE_300K: wrLen = WR_CYC_4M8;
			RATE_250K: wrLen = WR_CYC_4M;
			default: wrLen = WR_CYC_8M;
		endcase
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrCnt <= 5'h00;
			wrPulse <= 1'b0;
		end else if (!funcRun || !writeGateReq) begin
			wrCnt <= 5'h00;
			wrPulse <= 1'b0;
		end else if (writeBitReq && !wrPulse) begin
			wrCnt <= wrLen - 5'h01;
			wrPulse <= 1'b1;
		end else if (wrCnt != 5'h00) begin
			wrCnt <= wrCnt - 5'h01;
		end else begin
			wrPulse <= 1'b0;
		end
	end

	// step sequencer: direction set up, pulse, then hold past trailing edge
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stepState_reg <= STEP_IDLE;
			stepCnt <= 12'h000;
			stepDir_reg <= 1'b0;
			stepDone <= 1'b0;
		end else if (!funcRun) begin
			stepState_reg <= STEP_IDLE;
			stepCnt <= 12'h000;
			stepDone <= 1'b0;
		end else begin
			stepDone <= 1'b0;
			if (stepCnt != 12'h000) stepCnt <= stepCnt - 12'h001;
			case (stepState_reg)
				STEP_IDLE: if (stepReq) begin
					stepDir_reg <= stepOutward;
					stepCnt <= DIR_SETUP_CYC - 12'h001;
					stepState_reg <= STEP_SETUP;
				end
				STEP_SETUP: if (stepCnt == 12'h000) begin
					stepCnt <= STEP_ACTIVE_CYC - 12'h001;
					stepState_reg <= STEP_ACTIVE;
				end
				STEP_ACTIVE: if (stepCnt == 12'h000) begin
					stepCnt <= DIR_HOLD_CYC - 12'h001;
					stepState_reg <= STEP_HOLD;
				end
				STEP_HOLD: if (stepCnt == 12'h000) begin
					stepDone <= 1'b1;
					stepState_reg <= STEP_IDLE;
				end
				default: stepState_reg <= STEP_IDLE;
			endcase
		end
	end

	// drive outputs; everything toward the drives except motorA and motorB is low in function reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			driveOut.headSelect <= 1'b0;
			driveOut.step <= 1'b0;
			driveOut.direction <= 1'b0;
			driveOut.motorA <= 1'b0;
			driveOut.motorB <= 1'b0;
			driveOut.selectA <= 1'b0;
			driveOut.selectB <= 1'b0;
			driveOut.writeGate <= 1'b0;
			driveOut.writeData <= 1'b0;
			driveOut.reducedWrite <= 1'b0;
		end else begin
			driveOut.headSelect <= funcRun && headUpper;
			driveOut.step <= funcRun &&
				stepState_reg == STEP_ACTIVE;
			driveOut.direction <= funcRun && stepDir_reg;
			driveOut.motorA <= output_control_reg[OC_MOTOR_A];
			driveOut.motorB <= output_control_reg[OC_MOTOR_B];
			driveOut.selectA <= funcRun &&
				!output_control_reg[OC_DRIVE_SEL];
			driveOut.selectB <= funcRun &&
				output_control_reg[OC_DRIVE_SEL];
			driveOut.writeGate <= funcRun && writeGateReq;
			// gated again here so data never outlives the gate by a cycle
			driveOut.writeData <= funcRun && writeGateReq &&
				wrPulse;
			driveOut.reducedWrite <= funcRun &&
				rate_reg != RATE_500K;
		end
	end

	// core-side registered outputs
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cmdByte <= 8'h00;
			cmdAvail <= 1'b0;
			coreRun <= 1'b0;
			intDmaEnable <= 1'b0;
			driveInSync <= '1;
		end else begin
			cmdByte <= cmdMem[cmdRd];
			cmdAvail <= cmdCount != '0 && !doCmdPop;
			coreRun <= funcRun;
			intDmaEnable <= output_control_reg[OC_INT_DMA];
			driveInSync <= drvS;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	sequence stepPulse;
		driveOut.step [*8];
	endsequence

	a_write_gated: assert property (
		driveOut.writeData |-> driveOut.writeGate)
		else $error("write data pulse without write gate");
	a_write_width: assert property (
		$rose(driveOut.writeData) && rate_reg == RATE_500K && writeGateReq
		|-> ##14 (driveOut.writeData || !writeGateReq))
		else $error("write pulse shorter than rate width");
	a_step_trailing: assert property (
		$fell(driveOut.step) && funcRun
		|-> stepState_reg == STEP_HOLD)
		else $error("step ended outside hold phase");
	a_step_min_width: assert property (
		$rose(driveOut.step) && funcRun |-> stepPulse or !funcRun[*1])
		else $error("step pulse too short");
	a_dir_stable: assert property (
		driveOut.step && $past(driveOut.step)
		|-> $stable(driveOut.direction))
		else $error("direction moved during step");
	a_select_exclusive: assert property (
		!(driveOut.selectA && driveOut.selectB))
		else $error("both drives selected");
	a_reduced_rate: assert property (
		funcRun && rate_reg == RATE_500K ##1 funcRun
		|-> !driveOut.reducedWrite)
		else $error("reduced write at high density rate");
	a_outctl_reset: assert property (
		$rose(rstN) |-> output_control_reg == OUTCTL_RESET)
		else $error("output control not cleared");
	a_func_reset: assert property (
		!funcRun |=> cmdCount == '0 && !driveOut.selectA &&
		!driveOut.selectB)
		else $error("function reset not applied");
	a_dio_result: assert property (
		resCount != '0 |-> statusByte[6] && statusByte[7])
		else $error("result waiting but not flagged");
	a_fixed_hdc: assert property (
		!hostDataOe_n && $past(rdSel_reg) == SEL_FIXED
		|-> $past(hdcS, 2) && hostDataOut[7])
		else $error("fixed status answered with hard card");
	a_dma_quiet: assert property (
		aenS && !iowS |=> wrSel_reg == SEL_NONE)
		else $error("host write taken during DMA cycle");

endmodule // diskette_host_regs

// ### tb/drive_model.sv
// behavioural two-drive model: head position, track zero, index, protect
// assumes the drive outputs of the diskette block on the same clock
`timescale 1ns/100ps
module drive_model
	import diskette_regs_pkg::*;
#(
	parameter int REV_CYC    = 500,
	parameter bit PROTECT    = 1'b1,
	parameter int SPINUP_CYC = 300
) (
	input  wire logic                          clk,
	input  wire diskette_regs_pkg::drive_out_t driveOut,
	output diskette_regs_pkg::drive_in_t       driveIn,
	output logic                               early
);
	import diskette_regs_pkg::*;
	int   track      = 0;
	int   revCount   = 0;
	int   spin       = 0;
	logic stepLast   = 1'b0;
	logic writeEarly = 1'b0;
	// spin-up time is a scaled stand-in so the run stays short; a write
	// gated on before the selected motor has run that long is flagged
	always @(posedge clk) begin
		if ((driveOut.motorA && driveOut.selectA) ||
			(driveOut.motorB && driveOut.selectB)) spin <= spin + 1;
		else spin <= 0;
		if (driveOut.writeGate && spin < SPINUP_CYC)
			writeEarly <= 1'b1;
	end
	assign early = writeEarly;
	// heads move on the trailing edge of step, only on a selected drive
	always @(posedge clk) begin
		stepLast <= driveOut.step;
		if (stepLast && !driveOut.step &&
			(driveOut.selectA || driveOut.selectB)) begin
			if (driveOut.direction) begin
				track <= (track > 0) ? track - 1 : 0;
			end else begin
				track <= track + 1;
			end
		end
		revCount <= (revCount == REV_CYC - 1) ? 0 : revCount + 1;
	end
	// pins are active low; the change line simply reads set
	assign driveIn.trackZero_n    = (track != 0);
	assign driveIn.writeProtect_n = !PROTECT;
	assign driveIn.index_n        = (revCount >= 4);
	assign driveIn.diskChange     = 1'b1;
endmodule // drive_model

// ### tb/diskette_host_regs_and_drive_port_bench.sv
// self-checking bench for the diskette register bank and drive port
// assumes the drive model on the far side and host cycles on falling edges
`timescale 1ns/100ps
module diskette_host_regs_and_drive_port_bench;
	import diskette_regs_pkg::*;
	logic clk = 0, reset_n = 0, ioRead_n = 1, ioWrite_n = 1, addrEnable = 0;
	logic grp = 1, hdcN = 1, cmdPop = 0, resultPush = 0, stepReq = 0;
	logic stepOut = 0, headUp = 0, wGate = 0, wBit = 0;
	logic [9:0] addr = 0;
	logic [7:0] dIn = 0, dOut, cmdByte, resByte = 0, got;
	logic oeN, cmdAvail, stepDone, tick, coreRun, intDma, seen;
	logic densB = 0, early;
	// motor spin-up wait, matched to the drive model's stand-in
	localparam int SPIN_WAIT = 300;
	core_status_t cs = '0;
	drive_in_t dIn2, dSync;
	drive_out_t dOut2;
	int fails = 0, testsRun = 0, cyc = 0, n;
	diskette_host_regs #(.STACK_DEPTH(2)) DUT (.clk(clk), .reset_n(reset_n),
		.hostAddr(addr), .hostDataIn(dIn), .hostDataOut(dOut),
		.hostDataOe_n(oeN), .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n),
		.addrEnable(addrEnable), .driveGroupSelect(grp),
		.densityHighA(1'b1), .densityHighB(densB),
		.hard_disk_present_n(hdcN), .fixedDiskBits(7'h5A), .driveIn(dIn2),
		.driveOut(dOut2), .coreStatus(cs), .cmdPop(cmdPop),
		.cmdByte(cmdByte), .cmdAvail(cmdAvail), .resultPush(resultPush),
		.resultByte(resByte), .stepReq(stepReq), .stepOutward(stepOut),
		.headUpper(headUp), .writeGateReq(wGate), .writeBitReq(wBit),
		.stepDone(stepDone), .bitCellTick(tick), .coreRun(coreRun),
		.intDmaEnable(intDma), .driveInSync(dSync));
	drive_model #(.SPINUP_CYC(SPIN_WAIT)) MODEL (.clk(clk), .driveIn(dIn2),
		.driveOut(dOut2), .early(early));
	initial forever #5 clk = ~clk;
	// a hang is cut short well past the longest step sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		testsRun++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk) addr = a;
		dIn = d;
		ioWrite_n = 0;
		repeat (6) @(negedge clk);
		ioWrite_n = 1;
		repeat (6) @(negedge clk);
	endtask
	// seen tells whether the device drove the bus at all
	task automatic rd(input logic [9:0] a);
		@(negedge clk) addr = a;
		ioRead_n = 0;
		seen = 0;
		for (int i = 0; i < 12 && !seen; i++) begin
			@(negedge clk);
			seen = (oeN === 1'b0);
		end
		got = dOut;
		ioRead_n = 1;
		repeat (6) @(negedge clk);
	endtask
	task automatic t_reset();
		chk("drive outputs", 8'h00, 8'(dOut2 != '0));
		chk("run", 8'h00, 8'(coreRun));
		rd(10'h3F2);
		chk("wo read", 8'h00, 8'(seen));
	endtask
	task automatic t_regs();
		wr(10'h3F2, 8'h14);
		chk("motA selA run", 8'h15, {dOut2.motorA, dOut2.motorB,
			dOut2.selectA, dOut2.selectB, coreRun});
		rd(10'h3F1);
		chk("dtype", 8'h01, {4'h0, got[3:0]});
		rd(10'h1F7);
		chk("fixed", 8'h80, got);
		hdcN = 0;
		rd(10'h1F7);
		chk("fixed off", 8'h00, 8'(seen));
		rd(10'h3F7);
		chk("diag", 8'hDA, got);
	endtask
	task automatic t_stack();
		wr(10'h3F5, 8'hA5);
		chk("cmd", 8'hA5, cmdAvail ? cmdByte : 8'hXX);
		@(negedge clk) cmdPop = 1;
		resultPush = 1;
		resByte = 8'h3C;
		cs = '{1'b1, 1'b1, 1'b0, 1'b1};
		@(negedge clk) cmdPop = 0;
		resultPush = 0;
		repeat (3) @(negedge clk);
		rd(10'h3F4);
		chk("status", 8'hF1, got);
		rd(10'h3F5);
		chk("result", 8'h3C, got);
	endtask
	// one write bit request with the gate as given; counts the pulse
	task automatic pulse(input logic gate, input logic [7:0] want);
		@(negedge clk) wGate = gate;
		wBit = 1;
		@(negedge clk) wBit = 0;
		n = 0;
		repeat (40) @(negedge clk) n += dOut2.writeData;
		chk("wpulse", want, 8'(n));
	endtask
	task automatic t_rate();
		wr(10'h3F7, 8'h02);
		chk("reduced", 8'h01, 8'(dOut2.reducedWrite));
		wr(10'h3F7, 8'h03);
		chk("rsvd", 8'h01, 8'(dOut2.reducedWrite));
		// let the selected motor spin up before any write is gated on
		repeat (SPIN_WAIT) @(negedge clk);
		pulse(1'b1, 8'd25);
		pulse(1'b0, 8'd0);
		wr(10'h3F7, 8'h00);
		chk("normal", 8'h00, 8'(dOut2.reducedWrite));
		pulse(1'b1, 8'd15);
		wGate = 0;
		chk("spin-up", 8'h00, 8'(early));
		// let the period left from the slower rate run out, then count
		repeat (400) @(negedge clk);
		n = 0;
		repeat (1000) @(negedge clk) n += tick;
		chk("cell ticks", 8'd5, 8'(n));
	endtask
	task automatic t_step();
		headUp = 1;
		for (int s = 0; s < 2; s++) begin
			@(negedge clk) stepOut = (s == 1);
			stepReq = 1;
			@(negedge clk) stepReq = 0;
			// direction follows the latched request one cycle later
			@(negedge clk);
			chk("dir", 8'(s), 8'(dOut2.direction));
			for (int i = 0; i < 4000 && stepDone !== 1'b1; i++) @(negedge clk);
			chk("done", 8'h01, 8'(stepDone));
			repeat (4) @(negedge clk);
			chk("trk0", 8'(s == 0), 8'(dSync.trackZero_n));
		end
		chk("protect", 8'h00, 8'(dSync.writeProtect_n));
		n = 0;
		repeat (1000) @(negedge clk) n += !dSync.index_n;
		chk("index", 8'd8, 8'(n));
		chk("head", 8'h01, 8'(dOut2.headSelect));
	endtask
	task automatic t_misc();
		wr(10'h3F2, 8'h2D);
		chk("motB selB dma", 8'h0B, {dOut2.motorA, dOut2.motorB,
			dOut2.selectA, dOut2.selectB, intDma});
		addrEnable = 1;
		wr(10'h3F2, 8'h14);
		addrEnable = 0;
		chk("dma ignore", 8'h01, 8'(dOut2.motorB));
		grp = 0;
		densB = 1;
		rd(10'h371);
		chk("sec dtype", 8'h03, {4'h0, got[3:0]});
		rd(10'h3F1);
		chk("pri off", 8'h00, 8'(seen));
	endtask
	task automatic conclude();
		if (fails == 0 && testsRun > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1;
		repeat (4) @(negedge clk);
		t_reset();
		t_regs();
		t_stack();
		t_rate();
		t_step();
		t_misc();
		conclude();
	end
endmodule // diskette_host_regs_and_drive_port_bench
